// [dat_acq_timing.sv]
/*
 acquisition timing engine with its sample fifo and apb register file.
 assumes: adc data valid on the core clock; trigger and clk10 pins are
 asynchronous; the dma side drains with valid/ready.
*/
// The placing of the registers and register access over APB were decided locally.
// Operation
// - start acquiring on software, external or bus trigger
// - pace everything from 100 mhz timebase clock
// - offer internal 10 mhz reference as timebase
// - allow backplane clk10 as timebase source
// - clk100 timebase code ticks every core cycle, as onboard; no backplane clk100 pin
// - one sample every divider timebase ticks
// - sixteen-bit divider, rate is timebase over divider
// - push each sample into the fifo
// - forward fifo data to dma whenever non-empty
// - stop when sample count reaches target
// - thirty-two-bit sample count target
// - sixteen-bit trigger delay in timebase periods
// - thirty-two-bit trigger repeat count
// - one block per accepted trigger until used
// - rearm in the core cycle after block's last sample
// - run retriggered sequence without software help
// - post-trigger: wait for trigger, then acquire
// - delayed-trigger: wait programmed delay, then acquire
`timescale 1ns/100ps
module dat_fifo #(
	parameter int W = 16,
	parameter int DEPTH = 4
)
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic ce_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [W-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [W-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed
	{
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} dat_fifo_s;
	dat_fifo_s r;
	dat_fifo_s next_r;
	logic push;
	logic pop;

	assign in_ready_out = r.cnt != (AW+1)'(DEPTH);
	assign out_valid_out = r.cnt != '0;
	assign out_data_out = r.mem[r.rp];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;

	always_comb
	begin
		next_r = r;
		if (push)
		begin
			next_r.mem[r.wp] = in_data_in;
			next_r.wp = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + 1'b1;
		end
		if (pop)
			next_r.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + 1'b1;
		if (push && !pop)
			next_r.cnt = r.cnt + 1'b1;
		else if (pop && !push)
			next_r.cnt = r.cnt - 1'b1;
	end

	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			r <= '0;
		else if (ce_in)
			r <= next_r;
	end
endmodule

module dat_acq_timing
	import dat_pkg::*;
#(
	parameter int DATA_W = 16,
	parameter int FIFO_DEPTH = 4
)
(
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	input wire logic ce_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [DAT_ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic ext_trig_in,
	input wire logic bus_trig_in,
	input wire logic clk10_in,
	input wire logic [DATA_W-1:0] adc_data_in,
	output logic dma_valid_out,
	output logic [DATA_W-1:0] dma_data_out,
	input wire logic dma_ready_in,
	output logic busy_out
);
	typedef struct packed
	{
		dat_state_e st;
		logic busy;
		logic delay_en;
		logic [1:0] tb_sel;
		logic ext_en;
		logic bus_en;
		logic [15:0] interval;
		logic [31:0] target;
		logic [15:0] delay;
		logic [31:0] repeat_cnt;
		logic [15:0] intv_cnt;
		logic [15:0] dly_cnt;
		logic [31:0] blk_cnt;
		logic [31:0] total;
		logic [31:0] trigs;
		logic done;
		logic overrun;
		logic [3:0] div;
		logic [DAT_NPINS-1:0][2:0] sync;
		logic [DAT_NPINS-1:0] lvl;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic dvalid;
		logic [DATA_W-1:0] ddata;
	} dat_top_s;
	dat_top_s r;
	dat_top_s next_r;
	logic f_in_ready;
	logic f_out_valid;
	logic f_out_ready;
	logic [DATA_W-1:0] f_out_data;
	logic fire;

	// output stage loads whenever it is empty or being drained
	assign f_out_ready = !r.dvalid || dma_ready_in;

	dat_fifo #(
		.W(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_in(core_clk_in),
		.reset_n_in(reset_n_in),
		.ce_in(ce_in),
		.in_valid_in(fire),
		.in_ready_out(f_in_ready),
		.in_data_in(adc_data_in),
		.out_valid_out(f_out_valid),
		.out_ready_in(f_out_ready),
		.out_data_out(f_out_data)
	);

	always_comb
	begin
		logic access;
		logic wr;
		logic hit;
		logic [31:0] rd;
		logic [DAT_NPINS-1:0] rise;
		logic tick;
		logic due;
		logic trig;
		logic start;
		logic abort;
		access = psel_in && penable_in;
		wr = access && r.pready && pwrite_in;
		hit = 1'b1;
		rd = '0;
		rise = '0;
		tick = 1'b0;
		due = 1'b0;
		trig = 1'b0;
		start = 1'b0;
		abort = 1'b0;
		fire = 1'b0;
		next_r = r;

		// pins: a change counts once stages two and three agree
		for (int i = 0; i < DAT_NPINS; i++)
		begin
			next_r.sync[i] = {r.sync[i][1:0], 1'b0};
			if (r.sync[i][1] == r.sync[i][2])
			begin
				next_r.lvl[i] = r.sync[i][2];
				rise[i] = r.sync[i][2] && !r.lvl[i];
			end
		end
		next_r.sync[DAT_PIN_EXT][0] = ext_trig_in;
		next_r.sync[DAT_PIN_BUS][0] = bus_trig_in;
		next_r.sync[DAT_PIN_CLK10][0] = clk10_in;

		// timebase tick select
		next_r.div = (r.div >= DAT_REF10_DIV - 4'h1) ? '0 : r.div + 4'h1;
		case (r.tb_sel)
			DAT_TB_ONBOARD: tick = 1'b1;
			DAT_TB_REF10: tick = (r.div == '0);
			DAT_TB_CLK10: tick = rise[DAT_PIN_CLK10];
			DAT_TB_CLK100: tick = 1'b1;
			default: tick = 1'b1;
		endcase

		// apb read decode
		case (paddr_in)
			DAT_OFS_CTRL:
				rd = 32'({r.bus_en, r.ext_en, r.tb_sel, 1'b0, r.delay_en, 2'h0});
			DAT_OFS_INTERVAL: rd = 32'(r.interval);
			DAT_OFS_TARGET: rd = r.target;
			DAT_OFS_DELAY: rd = 32'(r.delay);
			DAT_OFS_REPEAT: rd = r.repeat_cnt;
			DAT_OFS_STATUS: rd = 32'({r.overrun, r.done, r.st, r.busy});
			DAT_OFS_SAMPLES: rd = r.total;
			DAT_OFS_TRIGS: rd = r.trigs;
			default: hit = 1'b0;
		endcase

		// one wait state, then answer; write lands at the answering edge
		if (access && !r.pready)
		begin
			next_r.pready = 1'b1;
			next_r.prdata = pwrite_in ? '0 : rd;
			next_r.pslverr = !hit;
		end
		else
		begin
			next_r.pready = 1'b0;
			next_r.pslverr = 1'b0;
		end

		if (wr && hit)
		begin
			case (paddr_in)
				DAT_OFS_CTRL:
				begin
					next_r.delay_en = pwdata_in[DAT_CTRL_DELAY_EN];
					next_r.tb_sel = pwdata_in[DAT_CTRL_TB_LO +: 2];
					next_r.ext_en = pwdata_in[DAT_CTRL_EXT_EN];
					next_r.bus_en = pwdata_in[DAT_CTRL_BUS_EN];
					start = pwdata_in[DAT_CTRL_START];
					abort = pwdata_in[DAT_CTRL_ABORT];
					trig = pwdata_in[DAT_CTRL_SW_TRIG];
				end
				DAT_OFS_INTERVAL: next_r.interval = pwdata_in[15:0];
				DAT_OFS_TARGET: next_r.target = pwdata_in;
				DAT_OFS_DELAY: next_r.delay = pwdata_in[15:0];
				DAT_OFS_REPEAT: next_r.repeat_cnt = pwdata_in;
				default: next_r.done = r.done;
			endcase
		end

		trig = trig || (r.ext_en && rise[DAT_PIN_EXT]) || (r.bus_en && rise[DAT_PIN_BUS]);

		// acquisition sequencer; software starts, triggers and aborts it
		case (r.st)
			DAT_IDLE:
			begin
				if (start)
				begin
					next_r.st = DAT_WAIT;
					next_r.blk_cnt = '0;
					next_r.total = '0;
					next_r.trigs = '0;
					next_r.done = 1'b0;
					next_r.overrun = 1'b0;
				end
			end
			DAT_WAIT:
			begin
				if (trig && r.delay_en)
				begin
					next_r.st = DAT_DELAY;
					next_r.dly_cnt = r.delay;
				end
				else if (trig)
				begin
					next_r.st = DAT_ACQ;
					next_r.intv_cnt = DAT_INTV_FIRST;
				end
			end
			DAT_DELAY:
			begin
				if (tick)
				begin
					// delay counts timebase periods, unit is one tick
					if (r.dly_cnt <= 16'h0001)
					begin
						next_r.st = DAT_ACQ;
						next_r.intv_cnt = DAT_INTV_FIRST;
					end
					else
						next_r.dly_cnt = r.dly_cnt - 16'h0001;
				end
			end
			DAT_ACQ:
			begin
				due = tick && (r.intv_cnt <= 16'h0001);
				if (tick && !due)
					next_r.intv_cnt = r.intv_cnt - 16'h0001;
				// full fifo stalls pacing instead of dropping a sample
				if (due && !f_in_ready)
					next_r.overrun = 1'b1;
				fire = due && f_in_ready;
				if (fire)
				begin
					next_r.intv_cnt = r.interval;
					next_r.total = r.total + 32'h1;
					next_r.blk_cnt = r.blk_cnt + 32'h1;
					if (r.blk_cnt + 32'h1 == r.target)
					begin
						next_r.blk_cnt = '0;
						next_r.trigs = r.trigs + 32'h1;
						if (r.trigs + 32'h1 >= r.repeat_cnt)
						begin
							next_r.st = DAT_IDLE;
							next_r.done = 1'b1;
						end
						else
							next_r.st = DAT_WAIT;
					end
				end
			end
			default: next_r.st = DAT_IDLE;
		endcase
		if (abort)
			next_r.st = DAT_IDLE;
		next_r.busy = (next_r.st != DAT_IDLE);

		// registered output stage toward the dma engine
		if (f_out_ready)
		begin
			next_r.dvalid = f_out_valid;
			next_r.ddata = f_out_data;
		end
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			r <= '0;
			r.st <= DAT_IDLE;
			r.interval <= DAT_RST_INTERVAL;
			r.target <= DAT_RST_TARGET;
			r.delay <= DAT_RST_DELAY;
			r.repeat_cnt <= DAT_RST_REPEAT;
		end
		else if (ce_in)
			r <= next_r;
	end

	assign prdata_out = r.prdata;
	assign pready_out = r.pready;
	assign pslverr_out = r.pslverr;
	assign dma_valid_out = r.dvalid;
	assign dma_data_out = r.ddata;
	assign busy_out = r.busy;
endmodule

// [dat_acq_timing_chk.sv]
/*
 port checker for the acquisition timing block.
 assumes one clock domain and the apb and stream handshakes of the block.
*/
`timescale 1ns/100ps
module dat_acq_timing_chk
	import dat_pkg::*;
#(
	parameter int DATA_W = 16
)
(
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	input wire logic ce_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [DAT_ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic dma_valid_out,
	input wire logic [DATA_W-1:0] dma_data_out,
	input wire logic dma_ready_in,
	input wire logic busy_out
);
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!reset_n_in);
	sequence wr_ctl;
		psel_in && penable_in && pready_out && pwrite_in && paddr_in == DAT_OFS_CTRL;
	endsequence
	sequence start_req;
		wr_ctl ##0 (pwdata_in[DAT_CTRL_START] && !pwdata_in[DAT_CTRL_ABORT] && !busy_out);
	endsequence
	sequence abort_req;
		wr_ctl ##0 pwdata_in[DAT_CTRL_ABORT];
	endsequence
	apb_wait_a: assert property (psel_in && penable_in && !pready_out |=> pready_out)
		else $error("no answer after one wait state");
	apb_pulse_a: assert property (pready_out |=> !pready_out)
		else $error("pready longer than one cycle");
	err_form_a: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
		else $error("error without ready or with data");
	err_map_a: assert property (psel_in && penable_in && pready_out && paddr_in >= 8'h20
		|-> pslverr_out) else $error("unmapped access accepted");
	dma_hold_a: assert property (dma_valid_out && !dma_ready_in
		|=> dma_valid_out && $stable(dma_data_out)) else $error("stream word lost");
	start_busy_a: assert property (start_req |-> ##[1:2] busy_out)
		else $error("start did not arm");
	abort_idle_a: assert property (abort_req |-> ##[1:3] !busy_out)
		else $error("abort did not stop");
	ce_freeze_a: assert property (!ce_in
		|=> $stable(busy_out) && $stable(dma_valid_out))
		else $error("flops moved with enable low");
endmodule
bind dat_acq_timing dat_acq_timing_chk #(.DATA_W(DATA_W)) u_chk (.core_clk_in, .reset_n_in,
	.ce_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
	.pready_out, .pslverr_out, .dma_valid_out, .dma_data_out, .dma_ready_in, .busy_out);

// [dat_dma_sink.sv]
/*
 dma engine model on the far side of the sample stream.
 assumes valid/ready taken at a rising edge; stall_in holds ready low.
*/
`timescale 1ns/100ps
module dat_dma_sink #(
	parameter int W = 16
)
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic stall_in,
	input wire logic valid_in,
	input wire logic [W-1:0] data_in,
	output logic ready_out
);
	logic [W-1:0] q[$];
	// ready moves only after an edge, like a real bus master
	always @(posedge clk_in or negedge reset_n_in)
		if (!reset_n_in)
			ready_out <= 1'b0;
		else
		begin
			ready_out <= !stall_in;
			if (valid_in && ready_out)
				q.push_back(data_in);
		end
endmodule

// [dat_pkg.sv]
/*
 package for the digitizer acquisition timing block: register map,
 field positions, reset values, timebase figures and state codes.
 assumes a 32-bit apb slave and a 100 mhz core clock.
*/
package dat_pkg;
	localparam int DAT_ADDR_W = 8;
	// register byte offsets
	localparam logic [7:0] DAT_OFS_CTRL = 8'h00;
	localparam logic [7:0] DAT_OFS_INTERVAL = 8'h04;
	localparam logic [7:0] DAT_OFS_TARGET = 8'h08;
	localparam logic [7:0] DAT_OFS_DELAY = 8'h0c;
	localparam logic [7:0] DAT_OFS_REPEAT = 8'h10;
	localparam logic [7:0] DAT_OFS_STATUS = 8'h14;
	localparam logic [7:0] DAT_OFS_SAMPLES = 8'h18;
	localparam logic [7:0] DAT_OFS_TRIGS = 8'h1c;
	// control field positions
	localparam int DAT_CTRL_START = 0;
	localparam int DAT_CTRL_ABORT = 1;
	localparam int DAT_CTRL_DELAY_EN = 2;
	localparam int DAT_CTRL_SW_TRIG = 3;
	localparam int DAT_CTRL_TB_LO = 4;
	localparam int DAT_CTRL_EXT_EN = 6;
	localparam int DAT_CTRL_BUS_EN = 7;
	// timebase source codes
	localparam logic [1:0] DAT_TB_ONBOARD = 2'h0;
	localparam logic [1:0] DAT_TB_REF10 = 2'h1;
	localparam logic [1:0] DAT_TB_CLK10 = 2'h2;
	localparam logic [1:0] DAT_TB_CLK100 = 2'h3;
	localparam int DAT_CORE_HZ = 100_000_000;
	localparam int DAT_REF10_HZ = 10_000_000;
	localparam logic [3:0] DAT_REF10_DIV = 4'(DAT_CORE_HZ / DAT_REF10_HZ);
	// reset values
	localparam logic [15:0] DAT_RST_INTERVAL = 16'h0001;
	localparam logic [31:0] DAT_RST_TARGET = 32'h0000_0001;
	localparam logic [15:0] DAT_RST_DELAY = 16'h0001;
	localparam logic [31:0] DAT_RST_REPEAT = 32'h0000_0001;
	localparam logic [15:0] DAT_INTV_FIRST = 16'h0001;
	// pin slots of the synchroniser bank
	localparam int DAT_PIN_EXT = 0;
	localparam int DAT_PIN_BUS = 1;
	localparam int DAT_PIN_CLK10 = 2;
	localparam int DAT_NPINS = 3;
	typedef enum logic [3:0]
	{
		DAT_IDLE = 4'h1,
		DAT_WAIT = 4'h2,
		DAT_DELAY = 4'h4,
		DAT_ACQ = 4'h8
	} dat_state_e;
endpackage

// [tb.sv]
/*
 self-checking bench for the acquisition timing block.
 assumes the dma model on the stream side and an apb master here.
*/
`timescale 1ns/100ps
module tb;
	import dat_pkg::*;
	logic clk, rst_n, ce, psel, pen, pwr, ext, bus, c10, stall, e, dv, rdy, busy;
	logic [7:0] pa;
	logic [31:0] pwd, prd, rd;
	logic prdy, perr;
	logic [15:0] adc, dd, t0, a;
	int n_fail, check_count;
	dat_acq_timing dut (.core_clk_in(clk), .reset_n_in(rst_n), .ce_in(ce), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
		.prdata_out(prd), .pready_out(prdy), .pslverr_out(perr), .ext_trig_in(ext),
		.bus_trig_in(bus), .clk10_in(c10), .adc_data_in(adc), .dma_valid_out(dv),
		.dma_data_out(dd), .dma_ready_in(rdy), .busy_out(busy));
	dat_dma_sink m (.clk_in(clk), .reset_n_in(rst_n), .stall_in(stall), .valid_in(dv),
		.data_in(dd), .ready_out(rdy));
	initial
	begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	// backplane 10 mhz, phase unrelated to the core clock
	initial
	begin
		c10 = 0;
		#3;
		forever #50 c10 = ~c10;
	end
	// adc word is a cycle stamp, so sample spacing is readable from data
	always @(posedge clk)
		adc <= rst_n ? adc + 16'h0001 : 16'h0000;
	task end_of_test;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] v, input logic [31:0] x);
		check_count++;
		if (v !== x)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, v, x);
		end
	endtask
	task tmo;
		n_fail++;
		$display("unexpected at %0t: wait ran out", $time);
		end_of_test;
	endtask
	task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= ad;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		for (i = 0; i < 50; i++)
		begin
			@(posedge clk);
			if (prdy === 1'b1)
				break;
		end
		if (i == 50)
			tmo;
		rd = prd;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task rdc(input logic [7:0] ad, input logic [31:0] x);
		apb(1'b0, ad, 32'h0);
		chk(rd, x);
	endtask
	task waitq(input int n);
		int i;
		for (i = 0; i < 3000 && m.q.size() < n; i++)
			@(posedge clk);
		if (i == 3000)
			tmo;
	endtask
	task waitidle;
		int i;
		for (i = 0; i < 3000 && busy !== 1'b0; i++)
			@(posedge clk);
		if (i == 3000)
			tmo;
	endtask
	task setup(input logic [31:0] c, iv, tg, rp, dl);
		apb(1'b1, DAT_OFS_INTERVAL, iv);
		apb(1'b1, DAT_OFS_TARGET, tg);
		apb(1'b1, DAT_OFS_DELAY, dl);
		apb(1'b1, DAT_OFS_REPEAT, rp);
		apb(1'b1, DAT_OFS_CTRL, c | 32'h1);
		// cleared late: last words of the previous run are still in flight at idle
		m.q.delete();
	endtask
	task trig(input logic [31:0] c);
		apb(1'b1, DAT_OFS_CTRL, c | 32'h8);
		t0 = adc;
	endtask
	task t_reset;
		rdc(DAT_OFS_INTERVAL, 32'h1);
		rdc(DAT_OFS_TARGET, 32'h1);
		rdc(DAT_OFS_DELAY, 32'h1);
		rdc(DAT_OFS_REPEAT, 32'h1);
		rdc(DAT_OFS_SAMPLES, 32'h0);
		rdc(8'h40, 32'h0);
		chk(32'(e), 32'h1);
	endtask
	task t_pace;
		setup(0, 3, 4, 1, 1);
		repeat (20) @(posedge clk);
		chk(m.q.size(), 0);
		trig(0);
		waitq(4);
		for (int i = 1; i < 4; i++)
			chk(32'(m.q[i] - m.q[i-1]), 32'h3);
		waitidle;
		rdc(DAT_OFS_SAMPLES, 32'h4);
		chk(m.q.size(), 4);
	endtask
	task t_src;
		logic [31:0] sp;
		for (int k = 0; k < 4; k++)
		begin
			// internal reference and backplane clk10 tick once per ten core cycles
			sp = (k == 1 || k == 2) ? 32'(DAT_CORE_HZ / DAT_REF10_HZ) : 32'h1;
			setup(k << 4, 1, 3, 1, 1);
			trig(k << 4);
			waitq(3);
			chk(32'(m.q[2] - m.q[1]), sp);
			waitidle;
		end
	endtask
	task t_delay;
		setup(0, 1, 2, 1, 1);
		trig(0);
		waitq(1);
		a = m.q[0] - t0;
		waitidle;
		setup(4, 1, 2, 1, 5);
		trig(4);
		waitq(1);
		chk(32'(m.q[0] - t0 - a), 32'h5);
		waitidle;
	endtask
	task t_retrig;
		setup(0, 1, 3, 2, 1);
		trig(0);
		waitq(3);
		repeat (5) @(posedge clk);
		rdc(DAT_OFS_STATUS, 32'h5);
		trig(0);
		waitq(6);
		waitidle;
		rdc(DAT_OFS_TRIGS, 32'h2);
		setup(0, 1, 3, 2, 1);
		apb(1'b1, DAT_OFS_CTRL, 32'h2);
		waitidle;
		rdc(DAT_OFS_TRIGS, 32'h0);
	endtask
	task t_pins;
		for (int p = 0; p < 2; p++)
		begin
			setup(p ? 32'h80 : 32'h40, 1, 2, 1, 1);
			@(posedge clk);
			ext <= !p;
			bus <= p;
			repeat (6) @(posedge clk);
			ext <= 1'b0;
			bus <= 1'b0;
			waitq(2);
			waitidle;
			chk(m.q.size(), 2);
		end
	endtask
	task t_fifo;
		stall <= 1'b1;
		setup(0, 1, 8, 1, 1);
		trig(0);
		repeat (20) @(posedge clk);
		ce <= 1'b0;
		repeat (3) @(posedge clk);
		ce <= 1'b1;
		chk(m.q.size(), 0);
		stall <= 1'b0;
		waitq(8);
		for (int i = 1; i < 8; i++)
			chk(32'(m.q[i] > m.q[i-1]), 32'h1);
		waitidle;
		rdc(DAT_OFS_STATUS, 32'h62);
	endtask
	initial
	begin
		rst_n = 0;
		ce = 1;
		psel = 0;
		pen = 0;
		pwr = 0;
		pa = 0;
		pwd = 0;
		ext = 0;
		bus = 0;
		stall = 0;
		n_fail = 0;
		check_count = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_pace;
		t_src;
		t_delay;
		t_retrig;
		t_pins;
		t_fifo;
		end_of_test;
	end
endmodule
